// ==== core/tsq_pkg.sv ====
// constants, bus and state types for the touch scan sequencer
package tsq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int OSC_PERIOD_NS  = 250;
  localparam int HALF_OSC_CYC   = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] HALF_DIV_MAX = 5'(HALF_OSC_CYC - 1);
  localparam logic [8:0] OH_XY_HALF   = 9'h005;
  localparam logic [8:0] OH_XYZ_HALF  = 9'h007;
  localparam logic [7:0] OH_DRIVE_CYC = 8'h0a;
  localparam logic [7:0] OH_CONV_CYC  = 8'h03;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_X      = 4'h0;
  localparam logic [3:0] ADDR_Y      = 4'h1;
  localparam logic [3:0] ADDR_Z1     = 4'h2;
  localparam logic [3:0] ADDR_Z2     = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_TIMING = 4'hb;
  localparam logic [3:0] ADDR_CTRL   = 4'hc;
  localparam logic [3:0] ADDR_FUNC   = 4'hd;
  localparam logic [3:0] ADDR_CFG2   = 4'he;

  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_RES12_BIT = 1;
  localparam int CFG2_PIN_LSB   = 14;
  localparam int CFG2_MED_LSB   = 12;
  localparam int CFG2_WIN_LSB   = 10;
  localparam int TIM_SETTLE_LSB = 0;
  localparam int TIM_PRE_LSB    = 4;
  localparam int TIM_SENSE_LSB  = 8;
  localparam int TIM_ADIV_LSB   = 12;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  localparam logic [15:0] TIM_RST  = 16'h0000;
  localparam logic [3:0]  FUNC_RST = 4'h0;

  localparam logic [3:0] FUNC_XYZ   = 4'h0;
  localparam logic [3:0] FUNC_XY    = 4'h1;
  localparam logic [1:0] PIN_PEN    = 2'h2;
  localparam logic [1:0] PIN_DAV_A  = 2'h3;
  localparam logic [1:0] PIN_DAV_B  = 2'h1;
  localparam logic [1:0] AX_X       = 2'h0;
  localparam logic [1:0] AX_Y       = 2'h1;
  localparam logic [1:0] AX_Z1      = 2'h2;
  localparam logic [1:0] AX_Z2      = 2'h3;
  localparam logic [3:0] MASK_XY    = 4'h3;
  localparam logic [3:0] MASK_XYZ   = 4'hf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_DRIVE = 5'h04,
    S_CONV  = 5'h08,
    S_PROC  = 5'h10
  } tsq_st_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tsq_bus_s;

  typedef struct packed {
    logic y_on;
    logic x_on;
    logic z_on;
    logic adc_on;
  } tsq_drive_s;

  typedef struct packed {
    tsq_st_e          st;
    logic [4:0]       div;
    logic [8:0]       cnt;
    logic [1:0]       axis;
    logic [4:0]       nconv;
    logic [15:0]      sum;
    logic [11:0]      mn;
    logic [11:0]      mx;
    logic [3:0][11:0] tmp;
    logic [3:0][11:0] res;
    logic [3:0]       unread;
    logic             processed_data_valid;
    logic [15:0]      ctrl;
    logic [15:0]      cfg2;
    logic [15:0]      tim;
    logic [3:0]       func;
    logic [15:0]      rdata;
    logic             pin;
    tsq_drive_s       drive;
  } tsq_state_s;

endpackage

// ==== core/tsq_scan_seq.sv ====
// touch scan sequencer: touch detect, y-x-z1-z2 scan, filtering, result latch
//
// Functional notes
// - function code 0000 runs x, y and pressure; 0001 runs x and y only.
// - touch drives the shared pin low when pin is set as pen request.
// - in autonomous mode a touch starts the scan unaided.
// - y goes first: drivers on, settle, then convert y.
// - filtering does several conversions; filtered value goes to a holding register.
// - x is driven and measured after y only while the panel stays touched.
// - x-y scan ends after x, copying new x and held y to results together.
// - pressure scan measures z1, z2; all four results update only at the end.
// - x-y set carries 2.5 oscillator cycles of startup overhead.
// - full set carries 3.5 oscillator cycles of startup overhead.
// - each drive phase adds 10 oscillator cycles to settle, precharge, sense.
// - each conversion takes (bits+2) converter clocks plus 3 oscillator cycles.
// - median and window fields both 00 mean one conversion per coordinate.
// - filter delay per coordinate follows median, window and resolution in median modes; it is a fixed 2 cycles when median is 00.
// - host mode starts the same scan only on that code write.
// - pin field 10 gives pen request, 11 or 01 gives data available.
// - data available sets on new results and holds until all are read.
// - results read right-justified in 16 bits, upper bits zero.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module tsq_scan_seq
  import tsq_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire tsq_pkg::tsq_bus_s    i_bus,
  input  wire logic                 i_pen_touch,
  input  wire logic [11:0]          i_adc_data,
  output logic [15:0]               o_rdata,
  output logic                      o_pen_or_data_ready_out,
  output tsq_pkg::tsq_drive_s       o_drive
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] f_nconv(input logic [1:0] med, input logic [1:0] win);
    logic [4:0] n;
    n = 5'h01;
    unique case (med)
      2'h0: begin
        unique case (win)
          2'h0: n = 5'h01;
          2'h1: n = 5'h04;
          2'h2: n = 5'h08;
          2'h3: n = 5'h10;
        endcase
      end
      2'h1: n = 5'h03;
      2'h2: n = 5'h07;
      2'h3: n = 5'h0f;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] f_lppro(input logic [1:0] med, input logic [1:0] win,
                                         input logic r12);
    logic [7:0] l;
    l = 8'h02;
    if (med == 2'h3) begin
      unique case (win)
        2'h0:    l = r12 ? 8'h1f : 8'h1d;
        2'h1:    l = r12 ? 8'h22 : 8'h20;
        default: l = r12 ? 8'h26 : 8'h24;
      endcase
    end else if (med == 2'h2 && win == 2'h1) begin
      l = r12 ? 8'h1f : 8'h1b;
    end else if (med != 2'h0) begin
      l = r12 ? 8'h1c : 8'h18;
    end
    return l;
  endfunction

  function automatic logic [8:0] f_halves(input logic [7:0] cyc);
    return {cyc, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tsq_state_s q;
  tsq_state_s d;

  logic       half_tick;
  logic       done;
  logic       r12;
  logic       is_xyz;
  logic       code_ok;
  logic       host_go;
  logic       last;
  logic [1:0] med;
  logic [1:0] win;
  logic [4:0] n_need;
  logic [7:0] drv_cyc;
  logic [7:0] conv_cyc;
  logic [8:0] drv_len;
  logic [8:0] conv_len;
  logic [8:0] proc_len;
  logic [11:0] smp;
  logic [11:0] filt;
  logic [12:0] mid;

  assign o_rdata                 = q.rdata;
  assign o_pen_or_data_ready_out = q.pin;
  assign o_drive                 = q.drive;

  always_comb begin
    d         = q;
    d.rdata   = 16'h0000;
    half_tick = (q.div == HALF_DIV_MAX);
    d.div     = half_tick ? 5'h00 : q.div + 5'h01;
    done      = half_tick && (q.cnt == 9'h001);
    if (half_tick && q.cnt != 9'h000) begin
      d.cnt = q.cnt - 9'h001;
    end

    r12     = q.ctrl[CTRL_RES12_BIT];
    med     = q.cfg2[CFG2_MED_LSB +: 2];
    win     = q.cfg2[CFG2_WIN_LSB +: 2];
    is_xyz  = (q.func == FUNC_XYZ);
    code_ok = (q.func == FUNC_XYZ) || (q.func == FUNC_XY);
    n_need  = f_nconv(med, win);
    // settle, precharge and sense in oscillator cycles on top of the fixed overhead
    drv_cyc  = OH_DRIVE_CYC + {4'h0, q.tim[TIM_SETTLE_LSB +: 4]}
               + {4'h0, q.tim[TIM_PRE_LSB +: 4]} + {4'h0, q.tim[TIM_SENSE_LSB +: 4]};
    drv_len  = f_halves(drv_cyc);
    conv_cyc = 8'((r12 ? 8'h0e : 8'h0c) << q.tim[TIM_ADIV_LSB +: 2]) + OH_CONV_CYC;
    conv_len = f_halves(conv_cyc);
    proc_len = f_halves(f_lppro(med, win, r12));
    smp      = r12 ? i_adc_data : {2'h0, i_adc_data[9:0]};
    // median modes use the mid-range of the extremes: no sorter, small area
    mid      = ({1'b0, q.mn} + {1'b0, q.mx}) >> 1;
    filt     = 12'h000;
    unique case (n_need)
      5'h04:   filt = q.sum[13:2];
      5'h08:   filt = q.sum[14:3];
      5'h10:   filt = q.sum[15:4];
      5'h01:   filt = q.sum[11:0];
      default: filt = mid[11:0];
    endcase

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    host_go = 1'b0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_X, ADDR_Y, ADDR_Z1, ADDR_Z2: begin
          d.rdata = {4'h0, q.res[i_bus.addr[1:0]]};
          d.unread[i_bus.addr[1:0]] = 1'b0;
        end
        ADDR_STATUS: d.rdata = {12'h000, is_xyz, q.st != S_IDLE, i_pen_touch, q.processed_data_valid};
        ADDR_TIMING: d.rdata = q.tim;
        ADDR_CTRL:   d.rdata = q.ctrl;
        ADDR_FUNC:   d.rdata = {12'h000, q.func};
        ADDR_CFG2:   d.rdata = q.cfg2;
        default:     d.rdata = 16'h0000;
      endcase
    end
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        ADDR_TIMING: d.tim  = i_bus.wdata;
        ADDR_CTRL:   d.ctrl = i_bus.wdata;
        ADDR_CFG2:   d.cfg2 = i_bus.wdata;
        ADDR_FUNC: begin
          // a code write during a scan is dropped so the running set stays coherent
          if (q.st == S_IDLE) begin
            d.func  = i_bus.wdata[3:0];
            host_go = !q.ctrl[CTRL_AUTO_BIT];
          end
        end
        default: ;
      endcase
    end
    if (d.unread == 4'h0) begin
      d.processed_data_valid = 1'b0;
    end

    // --------------------------------------------------------------
    // scan sequence
    // --------------------------------------------------------------
    last = (q.nconv + 5'h01 >= n_need);
    unique case (q.st)
      S_IDLE: begin
        if (i_pen_touch && ((q.ctrl[CTRL_AUTO_BIT] && code_ok)
            || (host_go && (i_bus.wdata[3:0] == FUNC_XYZ
                            || i_bus.wdata[3:0] == FUNC_XY)))) begin
          d.st   = S_START;
          d.axis = AX_Y;
          d.cnt  = (i_bus.wr && host_go ? i_bus.wdata[3:0] == FUNC_XYZ : is_xyz)
                   ? OH_XYZ_HALF : OH_XY_HALF;
        end
      end
      S_START: begin
        if (done) begin
          d.st  = S_DRIVE;
          d.cnt = drv_len;
        end
      end
      S_DRIVE: begin
        if (done) begin
          d.st    = S_CONV;
          d.cnt   = conv_len;
          d.nconv = 5'h00;
          d.sum   = 16'h0000;
          d.mn    = 12'hfff;
          d.mx    = 12'h000;
        end
      end
      S_CONV: begin
        if (done) begin
          d.sum   = q.sum + {4'h0, smp};
          d.mn    = (smp < q.mn) ? smp : q.mn;
          d.mx    = (smp > q.mx) ? smp : q.mx;
          d.nconv = q.nconv + 5'h01;
          d.cnt   = last ? proc_len : conv_len;
          d.st    = last ? S_PROC : S_CONV;
        end
      end
      S_PROC: begin
        if (done) begin
          d.tmp[q.axis] = filt;
          unique case (q.axis)
            AX_Y: begin
              d.axis = AX_X;
              d.st   = S_DRIVE;
              d.cnt  = drv_len;
            end
            AX_X: begin
              if (is_xyz) begin
                d.axis = AX_Z1;
                d.st   = S_DRIVE;
                d.cnt  = drv_len;
              end else begin
                // x is only in filt here; its holding slot loads on this same edge
                d.res[AX_X] = filt;
                d.res[AX_Y] = q.tmp[AX_Y];
                d.unread    = MASK_XY;
                d.processed_data_valid       = 1'b1;
                d.st        = S_IDLE;
              end
            end
            AX_Z1: begin
              // z2 shares the z1 drive setup, so it goes straight to conversion
              d.axis  = AX_Z2;
              d.st    = S_CONV;
              d.cnt   = conv_len;
              d.nconv = 5'h00;
              d.sum   = 16'h0000;
              d.mn    = 12'hfff;
              d.mx    = 12'h000;
            end
            AX_Z2: begin
              d.res      = q.tmp;
              d.res[AX_Z2] = filt;
              d.unread   = MASK_XYZ;
              d.processed_data_valid      = 1'b1;
              d.st       = S_IDLE;
            end
          endcase
        end
      end
      default: d.st = S_IDLE;
    endcase
    if (q.st != S_IDLE && !i_pen_touch) begin
      d.st = S_IDLE;
    end

    // --------------------------------------------------------------
    // panel drivers and shared pin
    // --------------------------------------------------------------
    d.drive        = '0;
    if (d.st == S_DRIVE || d.st == S_CONV || d.st == S_PROC) begin
      d.drive.y_on = (d.axis == AX_Y);
      d.drive.x_on = (d.axis == AX_X);
      d.drive.z_on = (d.axis == AX_Z1) || (d.axis == AX_Z2);
    end
    d.drive.adc_on = (d.st == S_CONV);
    unique case (d.cfg2[CFG2_PIN_LSB +: 2])
      PIN_PEN:              d.pin = !i_pen_touch;
      PIN_DAV_A, PIN_DAV_B: d.pin = !d.processed_data_valid;
      default:              d.pin = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.ctrl <= CTRL_RST;
      q.cfg2 <= CFG2_RST;
      q.tim  <= TIM_RST;
      q.func <= FUNC_RST;
      q.pin  <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule

// ==== verif/touch_scan_sequencer_tb_top.sv ====
// register-level testbench for the touch scan sequencer
`timescale 1ns/1ps
module touch_scan_sequencer_tb_top;
  import tsq_pkg::*;
  logic        i_clk;
  logic        i_rst;
  tsq_bus_s    bus;
  logic        touch;
  logic [11:0] adc;
  logic [11:0] ofs;
  logic [15:0] rdata;
  logic        pin;
  tsq_drive_s  drv;
  int          err_count;
  int          checks_done;
  int          n;
  logic        hit;
  logic [3:0]  rl [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hb, 4'hc, 4'hd, 4'he, 4'h5};

  tsq_scan_seq dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .i_pen_touch(touch),
    .i_adc_data(adc), .o_rdata(rdata), .o_pen_or_data_ready_out(pin), .o_drive(drv));
  tsq_panel_model panel_u (.i_clk(i_clk), .i_drive(drv), .i_ofs(ofs), .o_adc_data(adc));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      err_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  // counts cycles until the pin goes low, bounded
  task automatic wait_low(input int mx, output int k);
    k = 0;
    while (pin !== 1'b0 && k < mx) begin
      @(negedge i_clk);
      k++;
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    bus = '0;
    touch = 1'b0;
    ofs = 12'h000;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rl[i]) rd(rl[i], 16'h0000);
    // reset code 0000 selects the full set, so status shows it
    rd(ADDR_STATUS, 16'h0008);
    chk("pin idle", 16'h1, {15'h0, pin});
    wr(ADDR_TIMING, 16'h3fff);
    rd(ADDR_TIMING, 16'h3fff);
    wr(ADDR_TIMING, 16'h0000);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h0000);
    // autonomous x-y scan, pin as data ready
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_FUNC, {12'h0, FUNC_XY});
    wr(ADDR_CFG2, 16'hc000);
    @(posedge i_clk);
    touch <= 1'b1;
    wait_low(4000, n);
    rng("xy time", 2790, 2840, n);
    @(posedge i_clk);
    touch <= 1'b0;
    rd(ADDR_X, 16'h02b6);
    chk("pin held", 16'h0, {15'h0, pin});
    rd(ADDR_Y, 16'h01a5);
    repeat (2) @(negedge i_clk);
    chk("pin freed", 16'h1, {15'h0, pin});
    rd(ADDR_Z1, 16'h0000);
    // touch lost during x phase
    @(posedge i_clk);
    ofs <= 12'h010;
    touch <= 1'b1;
    n = 0;
    while (drv.x_on !== 1'b1 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    rng("x reached", 1, 3999, n);
    @(posedge i_clk);
    touch <= 1'b0;
    repeat (10) @(negedge i_clk);
    chk("drive off", 16'h0, {12'h0, drv});
    rd(ADDR_STATUS, 16'h0000);
    rd(ADDR_X, 16'h02b6);
    // host mode: pen request, then scan on code write
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CFG2, 16'h8000);
    @(posedge i_clk);
    touch <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk("pen pin", 16'h0, {15'h0, pin});
    hit = 1'b0;
    repeat (3000) begin
      @(negedge i_clk);
      if (drv.y_on !== 1'b0) hit = 1'b1;
    end
    chk("no self start", 16'h0, {15'h0, hit});
    rd(ADDR_STATUS, 16'h0002);
    wr(ADDR_CFG2, 16'hc000);
    wr(ADDR_FUNC, {12'h0, FUNC_XYZ});
    wait_low(8000, n);
    rng("xyz time", 5040, 5090, n);
    @(posedge i_clk);
    touch <= 1'b0;
    rd(ADDR_X, 16'h02c6);
    rd(ADDR_Y, 16'h01b5);
    rd(ADDR_Z1, 16'h00d3);
    rd(ADDR_Z2, 16'h03e4);
    // 12-bit, median of three, no window
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_FUNC, {12'h0, FUNC_XY});
    // pin field 01: the second data-ready code
    wr(ADDR_CFG2, 16'h5000);
    @(posedge i_clk);
    touch <= 1'b1;
    wait_low(12000, n);
    rng("filter time", 8990, 9040, n);
    @(posedge i_clk);
    touch <= 1'b0;
    rd(ADDR_X, 16'h02c6);
    rd(ADDR_Y, 16'h01b5);
    print_verdict;
  end
endmodule

// ==== verif/tsq_panel_model.sv ====
// panel and converter stand-in answering the drive enables
`timescale 1ns/1ps
module tsq_panel_model
  import tsq_pkg::*;
(
  input  wire logic                i_clk,
  input  wire tsq_pkg::tsq_drive_s i_drive,
  input  wire logic [11:0]         i_ofs,
  output logic [11:0]              o_adc_data
);
  logic        z2_q    = 1'b0;
  logic        adc_q   = 1'b0;
  logic [11:0] noise_q = 12'h000;
  always_ff @(posedge i_clk) begin
    adc_q   <= i_drive.adc_on;
    noise_q <= noise_q + 12'h5a7;
    if (!i_drive.z_on) z2_q <= 1'b0;
    else if (adc_q && !i_drive.adc_on) z2_q <= 1'b1;
  end
  // converter off: value churns so a stale sample never matches
  always_comb begin
    if (!i_drive.adc_on) o_adc_data = noise_q;
    else if (i_drive.y_on) o_adc_data = 12'h1a5 + i_ofs;
    else if (i_drive.x_on) o_adc_data = 12'h2b6 + i_ofs;
    else if (z2_q) o_adc_data = 12'h3d4 + i_ofs;
    else o_adc_data = 12'h0c3 + i_ofs;
  end
endmodule

// ==== verif/tsq_scan_seq_checker.sv ====
// port checker for the touch scan sequencer
`timescale 1ns/1ps
module tsq_scan_seq_checker
  import tsq_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire tsq_pkg::tsq_bus_s   i_bus,
  input wire logic                i_pen_touch,
  input wire logic [11:0]         i_adc_data,
  input wire logic [15:0]         o_rdata,
  input wire logic                o_pen_or_data_ready_out,
  input wire tsq_pkg::tsq_drive_s o_drive
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [1:0]  pin_fn_q;
  logic [19:0] y_gap_q;
  logic [15:0] set_q;
  logic [2:0]  drv_q;
  logic [2:0]  drv_now;
  assign drv_now = {o_drive.y_on, o_drive.x_on, o_drive.z_on};
  // gap counter is forced to its maximum while drivers idle, so x needs a y in the same set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_fn_q <= 2'h0;
      y_gap_q  <= 20'hfffff;
      set_q    <= 16'h0000;
      drv_q    <= 3'h0;
    end else begin
      drv_q <= drv_now;
      if (i_bus.wr && i_bus.addr == ADDR_CFG2) pin_fn_q <= i_bus.wdata[15:14];
      if (o_drive.y_on) y_gap_q <= 20'h00000;
      else if (drv_now == 3'h0) y_gap_q <= 20'hfffff;
      else if (y_gap_q != 20'hfffff) y_gap_q <= y_gap_q + 20'h00001;
      if (drv_now != drv_q) set_q <= 16'h0000;
      else if (!o_drive.adc_on && set_q != 16'hffff) set_q <= set_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_result_upper: assert property (i_bus.rd && i_bus.addr < ADDR_STATUS |=> o_rdata[15:12] == 4'h0)
    else $error("result upper bits not zero");
  chk_drive_excl: assert property ($onehot0(drv_now))
    else $error("two panel drivers on at once");
  chk_touch_loss: assert property ($fell(i_pen_touch) |-> ##[1:3] (o_drive == 4'h0))
    else $error("scan not abandoned after touch loss");
  chk_x_after_y: assert property ($rose(o_drive.x_on) |-> y_gap_q != 20'hfffff)
    else $error("x phase without y phase");
  chk_adc_driven: assert property ($rose(o_drive.adc_on) |-> drv_now != 3'h0)
    else $error("converter on with no driver");
  chk_settle_min: assert property ($rose(o_drive.adc_on) |-> set_q >= 16'd475)
    else $error("drive phase too short");
  chk_pen_pin: assert property ((pin_fn_q == PIN_PEN && i_pen_touch) [*2] |-> !o_pen_or_data_ready_out)
    else $error("pen request pin not low");
  chk_dav_hold: assert property ($rose(o_pen_or_data_ready_out) && pin_fn_q[0] && pin_fn_q == $past(pin_fn_q, 2)
    |-> $past(i_bus.rd) || $past(i_bus.rd, 2))
    else $error("data ready cleared without a read");

  cov_x_phase: cover property ($rose(o_drive.x_on));
  cov_z_phase: cover property ($rose(o_drive.z_on));
  cov_abort:   cover property ($fell(i_pen_touch) && o_drive.x_on);
  cov_pen:     cover property ($fell(o_pen_or_data_ready_out) && pin_fn_q == PIN_PEN);
endmodule

bind tsq_scan_seq tsq_scan_seq_checker chk_u (.i_clk, .i_rst, .i_bus, .i_pen_touch, .i_adc_data,
  .o_rdata, .o_pen_or_data_ready_out, .o_drive);
